// ---- rtl/dram_ctl_end.sv ----
// Memory controller end with its write-data FIFO.
// Assumes a register master on ref_clk and CK_HALF of at least 4.
`timescale 1ns/10ps
`default_nettype none
module wdata_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
)(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [PTR_W-1:0] wr_q;
	logic [PTR_W-1:0] rd_q;
	logic [CNT_W-1:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != CNT_W'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_q];

	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wr_q] <= in_data;
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + CNT_W'(push) - CNT_W'(pop);
		end
	end
endmodule

module dram_ctl_end
	import dram_lat_pkg::*;
#(
	parameter int CK_HALF = CK_HALF_CYC,
	parameter int FIFO_DEPTH = 4
)(
	input wire logic ref_clk,
	input wire logic sys_rst,
	dram_link_if.ctl link,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic wdata_ready
);
	typedef enum logic [1:0] {
		C_IDLE = 2'b00,
		C_SEL = 2'b01,
		C_RUN = 2'b10
	} ctl_state_t;

	localparam int DIV_W = $clog2(CK_HALF + 1);
	localparam logic [CAL_W-1:0] CAL_ONE = 3'h1;

	logic [DIV_W-1:0] div_q;
	logic ck_q;
	logic tick;
	logic rise_ev;
	logic fall_ev;
	logic [DQ_W-1:0] dq_s1_q, dq_s2_q;
	logic [1:0] st_s1_q, st_s2_q;
	logic dbi_n_s;
	logic dll_s;
	cfg_t cfg_q;
	ctl_state_t state_q;
	logic pend_q;
	logic [1:0] op_q;
	logic [ADDR_W-1:0] op_addr_q;
	logic [CAL_W-1:0] cal_q;
	logic [LAT_W:0] rel_q;
	logic [LAT_W:0] nxt;
	logic [LAT_W:0] lat_q;
	logic [LAT_W:0] len_q;
	logic cs_n_q;
	logic [1:0] cmd_q;
	logic [ADDR_W-1:0] addr_q;
	logic par_q;
	logic odt_q;
	logic [DQ_W-1:0] dq_o_q;
	logic dq_oe_q;
	logic refused_q;
	logic underrun_q;
	logic [DQ_W-1:0] rbuf [0:RBUF_WORDS-1];
	logic [31:0] rdata_q;
	logic [7:0] roff;
	logic fifo_valid;
	logic [DQ_W-1:0] fifo_data;
	logic wbeat;
	logic rbeat;
	logic [LAT_W:0] ridx;
	logic cmd_wr;
	logic cfg_wr;
	logic accept;
	logic busy;

	wdata_fifo #(.WIDTH(DQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.in_valid(reg_wr && reg_addr == REG_WDATA),
		.in_ready(wdata_ready),
		.in_data(reg_wdata[DQ_W-1:0]),
		.out_valid(fifo_valid),
		.out_ready(fall_ev && wbeat),
		.out_data(fifo_data)
	);

	// Link clock divider; outputs change on falling ck, sampled on rising
	assign tick = (div_q == DIV_W'(CK_HALF - 1));
	assign rise_ev = tick && !ck_q;
	assign fall_ev = tick && ck_q;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			div_q <= '0;
			ck_q <= 1'b0;
		end
		else
		begin
			div_q <= tick ? '0 : div_q + 1'b1;
			if (tick)
				ck_q <= ~ck_q;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dq_s1_q <= '0;
			dq_s2_q <= '0;
			st_s1_q <= 2'h1;
			st_s2_q <= 2'h1;
		end
		else
		begin
			dq_s1_q <= link.dq;
			dq_s2_q <= dq_s1_q;
			st_s1_q <= {link.dll_ok, link.dbi_n};
			st_s2_q <= st_s1_q;
		end
	end

	assign {dll_s, dbi_n_s} = st_s2_q;
	assign busy = pend_q || state_q != C_IDLE;
	assign cmd_wr = reg_wr && reg_addr == REG_CMD;
	assign cfg_wr = reg_wr && reg_addr == REG_CFG;
	// Writes need a full FIFO and a locked DLL on the far side, else are refused
	assign accept = !busy && (cfg_wr || (cmd_wr && (!reg_wdata[CMDF_WRITE]
		|| (dll_s && !wdata_ready)))); // [R7]
	assign nxt = rel_q + 1'b1;
	assign wbeat = state_q == C_RUN && op_q == CMD_WR && nxt >= lat_q
		&& nxt < lat_q + len_q; // [R5]
	assign rbeat = state_q == C_RUN && op_q == CMD_RD && rel_q > lat_q
		&& rel_q <= lat_q + len_q; // [R4] [R9]
	assign ridx = rel_q - lat_q - 1'b1;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cfg_q <= CFG_RST;
			pend_q <= 1'b0;
			op_q <= CMD_NOP;
			op_addr_q <= '0;
		end
		else if (accept && cfg_wr)
		begin
			op_q <= CMD_MRS;
			op_addr_q <= reg_wdata[ADDR_W-1:0];
			pend_q <= 1'b1;
		end
		else if (accept)
		begin
			op_q <= reg_wdata[CMDF_WRITE] ? CMD_WR : CMD_RD;
			op_addr_q <= '0;
			op_addr_q[A12_BIT] <= reg_wdata[CMDF_A12]; // [R3] [R10]
			op_addr_q[COL_W-1:0] <= reg_wdata[CMDF_COL +: COL_W];
			pend_q <= 1'b1;
		end
		else if (fall_ev && state_q == C_IDLE)
		begin
			pend_q <= 1'b0;
			// New image applies as the mode-set leaves: its own select
			// must still follow the latency mode the device holds now
			if (pend_q && op_q == CMD_MRS)
				cfg_q <= cfg_t'(op_addr_q); // [R11]
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= C_IDLE;
			cal_q <= '0;
			rel_q <= '0;
			lat_q <= '0;
			len_q <= '0;
			cs_n_q <= 1'b1;
			cmd_q <= CMD_NOP;
			addr_q <= '0;
			par_q <= 1'b0;
			odt_q <= 1'b0;
		end
		else if (fall_ev)
		begin
			cs_n_q <= 1'b1;
			cmd_q <= CMD_NOP;
			case (state_q)
				C_IDLE:
				begin
					if (pend_q)
					begin
						cs_n_q <= 1'b0;
						cal_q <= cfg_q.cal;
						lat_q <= (op_q == CMD_RD) ? (LAT_W + 1)'(read_lat(cfg_q))
							: (LAT_W + 1)'(write_lat(cfg_q));
						len_q <= (op_q == CMD_MRS) ? '0 : (LAT_W + 1)'(
							burst_beats(cfg_q.bf, op_addr_q[A12_BIT])); // [R1] [R2]
						state_q <= (cfg_q.cal == '0) ? C_RUN : C_SEL;
						rel_q <= '0;
						if (cfg_q.cal == '0)
						begin
							cmd_q <= op_q;
							addr_q <= op_addr_q;
							par_q <= ^{op_q, op_addr_q};
							odt_q <= (op_q == CMD_WR);
						end
					end
				end
				C_SEL:
				begin
					cal_q <= cal_q - CAL_ONE;
					// Command lands cal clocks after the select edge
					if (cal_q == CAL_ONE)
					begin
						cmd_q <= op_q; // [R11]
						addr_q <= op_addr_q;
						par_q <= ^{op_q, op_addr_q};
						odt_q <= (op_q == CMD_WR); // [R6]
						state_q <= C_RUN;
					end
				end
				C_RUN:
				begin
					rel_q <= nxt;
					if (nxt == lat_q + len_q + 1'b1)
					begin
						state_q <= C_IDLE;
						odt_q <= 1'b0;
					end
				end
				default: state_q <= C_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dq_o_q <= '0;
			dq_oe_q <= 1'b0;
			refused_q <= 1'b0;
			underrun_q <= 1'b0;
		end
		else
		begin
			if (fall_ev)
			begin
				dq_oe_q <= wbeat;
				dq_o_q <= (wbeat && fifo_valid) ? fifo_data : '0;
			end
			// Sticky flags: a new event in the clearing cycle still sets
			if ((cmd_wr || cfg_wr) && !accept
				|| reg_wr && reg_addr == REG_WDATA && !wdata_ready)
				refused_q <= 1'b1;
			else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_REFUSED])
				refused_q <= 1'b0;
			if (fall_ev && wbeat && !fifo_valid)
				underrun_q <= 1'b1;
			else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_UNDERRUN])
				underrun_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rise_ev && rbeat)
			rbuf[ridx[2:0]] <= (cfg_q.rdbi && !dbi_n_s) ? ~dq_s2_q : dq_s2_q; // [R8]
	end

	assign roff = reg_addr - REG_RDATA;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rdata_q <= '0;
		else if (reg_rd)
		begin
			rdata_q <= '0;
			if (reg_addr == REG_CFG)
				rdata_q <= 32'(cfg_q);
			else if (reg_addr == REG_STATUS)
			begin
				rdata_q[ST_BUSY] <= busy;
				rdata_q[ST_DLL] <= dll_s;
				rdata_q[ST_FULL] <= !wdata_ready;
				rdata_q[ST_EMPTY] <= !fifo_valid;
				rdata_q[ST_REFUSED] <= refused_q;
				rdata_q[ST_UNDERRUN] <= underrun_q;
			end
			else if (reg_addr >= REG_RDATA && reg_addr < REG_RDATA_END)
				rdata_q <= 32'(rbuf[roff[4:2]]);
		end
	end

	assign reg_rdata = rdata_q;
	assign link.ck = ck_q;
	assign link.cs_n = cs_n_q;
	assign link.cmd = cmd_q;
	assign link.addr = addr_q;
	assign link.par = par_q;
	assign link.odt = odt_q;
	assign link.dq_c_o = dq_o_q;
	assign link.dq_c_oe = dq_oe_q;
endmodule
`default_nettype wire

// ---- rtl/dram_lat_pkg.sv ----
// Shared constants, mode-register layout and latency functions for the
// command-latency DRAM link. Both ends and the link interface import this.
package dram_lat_pkg;
	localparam int DQ_W = 8;
	localparam int ADDR_W = 22;
	localparam int COL_W = 4;
	localparam int LAT_W = 7;
	localparam int BEAT_W = 4;
	localparam int CAL_W = 3;
	localparam int A12_BIT = 12;
	localparam int DBI_ZERO_LIMIT = DQ_W / 2;

	// Command codes on the link, sampled with chip select, or cal clocks after it in latency mode
	localparam logic [1:0] CMD_NOP = 2'h0;
	localparam logic [1:0] CMD_MRS = 2'h1;
	localparam logic [1:0] CMD_RD = 2'h2;
	localparam logic [1:0] CMD_WR = 2'h3;

	// Burst field encodings
	localparam logic [1:0] BF_BL8 = 2'h0;
	localparam logic [1:0] BF_OTF = 2'h1;
	localparam logic [1:0] BF_BC4 = 2'h2;
	localparam logic [BEAT_W-1:0] BEATS_BL8 = 4'h8;
	localparam logic [BEAT_W-1:0] BEATS_BC4 = 4'h4;

	// Latency adders in link clocks
	localparam logic [LAT_W-1:0] PAR_LAT = 7'h04;
	localparam logic [LAT_W-1:0] RDBI_LAT = 7'h02;

	// Link clock made by the controller from ref_clk
	localparam int REF_PERIOD_NS = 8;
	localparam int CK_PERIOD_NS = 64;
	localparam int CK_HALF_CYC = CK_PERIOD_NS / (2 * REF_PERIOD_NS);

	// Mode register image, carried on the address bus by a mode-set command
	typedef struct packed {
		logic [4:0] al;
		logic [4:0] cwl;
		logic [4:0] cl;
		logic [CAL_W-1:0] cal;
		logic rdbi;
		logic par;
		logic [1:0] bf;
	} cfg_t;

	localparam cfg_t CFG_RST = '{al: 5'h00, cwl: 5'h09, cl: 5'h0b,
		cal: 3'h0, rdbi: 1'b0, par: 1'b0, bf: BF_BL8};

	// Controller register map and fields
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_RDATA_END = 8'h30;
	localparam int ST_BUSY = 0;
	localparam int ST_DLL = 1;
	localparam int ST_FULL = 2;
	localparam int ST_EMPTY = 3;
	localparam int ST_REFUSED = 4;
	localparam int ST_UNDERRUN = 5;
	localparam int CMDF_WRITE = 0;
	localparam int CMDF_A12 = 1;
	localparam int CMDF_COL = 2;
	localparam int RBUF_WORDS = 8;

	function automatic logic [BEAT_W-1:0] burst_beats(input logic [1:0] bf,
		input logic a12);
		case (bf)
			BF_BC4: burst_beats = BEATS_BC4;
			BF_OTF: burst_beats = a12 ? BEATS_BL8 : BEATS_BC4;
			default: burst_beats = BEATS_BL8;
		endcase
	endfunction

	function automatic logic [LAT_W-1:0] read_lat(input cfg_t c);
		read_lat = LAT_W'(c.cl) + LAT_W'(c.al) + (c.par ? PAR_LAT : '0)
			+ (c.rdbi ? RDBI_LAT : '0);
	endfunction

	function automatic logic [LAT_W-1:0] write_lat(input cfg_t c);
		write_lat = LAT_W'(c.cwl) + LAT_W'(c.al) + (c.par ? PAR_LAT : '0);
	endfunction
endpackage

// ---- rtl/dram_link_if.sv ----
// Link between memory controller and DRAM device end.
// Assumes both ends run on the same ref_clk; the link clock is a plain wire.
`timescale 1ns/10ps
`default_nettype none
interface dram_link_if;
	import dram_lat_pkg::*;
	logic ck;
	logic cs_n;
	logic [1:0] cmd;
	logic [ADDR_W-1:0] addr;
	logic par;
	logic odt;
	logic [DQ_W-1:0] dq_c_o;
	logic dq_c_oe;
	logic [DQ_W-1:0] dq_d_o;
	logic dq_d_oe;
	logic [DQ_W-1:0] dq;
	logic dbi_n;
	logic dll_ok;

	// Shared data bus; idles high like a terminated line
	assign dq = dq_c_oe ? dq_c_o : (dq_d_oe ? dq_d_o : '1);

	modport ctl (output ck, cs_n, cmd, addr, par, odt, dq_c_o, dq_c_oe,
		input dq, dbi_n, dll_ok);
	modport dev (input ck, cs_n, cmd, addr, par, odt, dq,
		output dq_d_o, dq_d_oe, dbi_n, dll_ok);
endinterface
`default_nettype wire

// ---- rtl/dram_dev_end.sv ----
// DRAM device end: burst length, latency modes, read inversion, small array.
// Assumes the link clock and all link inputs are no faster than ref_clk/8.
// Summary of operation
// [R1] Field 00, or 01 with A12 high: eight beats
// [R2] Field 10: every burst four beats, A12 ignored
// [R3] Field 01 with A12 low: four beats
// [R4] Parity on: read latency gains parity latency
// [R5] Parity on: write latency gains parity latency
// [R6] Command latency mode leaves termination timing alone
// [R7] Write timing holds only with DLL locked
// [R8] Read inversion: per-beat inversion flag with data
// [R9] Read inversion adds two clocks read latency
// [R10] Write, field 01: A12 picks four or eight
// [R11] Command latency: command sampled clocks after select
`timescale 1ns/10ps
`default_nettype none
module dram_dev_end
	import dram_lat_pkg::*;
#(
	parameter int MEM_WORDS = 2 ** COL_W
)(
	input wire logic ref_clk,
	input wire logic sys_rst,
	dram_link_if.dev link,
	input wire logic dll_locked,
	output logic odt_active,
	output logic busy,
	output logic par_err,
	output logic wr_dropped
);
	typedef enum logic [1:0] {
		D_IDLE = 2'b00,
		D_CAL = 2'b01,
		D_LAT = 2'b10,
		D_XFER = 2'b11
	} dev_state_t;

	localparam int SYN_W = 4 + 2 + ADDR_W + DQ_W;
	localparam logic [CAL_W-1:0] CAL_ONE = 3'h1;
	localparam logic [LAT_W-1:0] LAT_ONE = 7'h01;

	logic [SYN_W-1:0] syn1_q;
	logic [SYN_W-1:0] syn2_q;
	logic ck_s;
	logic cs_n_s;
	logic par_s;
	logic odt_s;
	logic [1:0] cmd_s;
	logic [ADDR_W-1:0] addr_s;
	logic [DQ_W-1:0] dq_s;
	logic ck_prev_q;
	logic rise;
	dev_state_t state_q;
	cfg_t cfg_q;
	logic [CAL_W-1:0] cal_q;
	logic [LAT_W-1:0] lat_q;
	logic [BEAT_W-1:0] beat_q;
	logic [BEAT_W-1:0] len_q;
	logic [COL_W-1:0] col_q;
	logic is_wr_q;
	logic dll_s1_q;
	logic dll_q;
	logic [DQ_W-1:0] mem [0:MEM_WORDS-1];
	logic [DQ_W-1:0] dq_o_q;
	logic dq_oe_q;
	logic dbi_n_q;
	logic odt_q;
	logic par_err_q;
	logic wr_drop_q;
	logic take;
	logic par_good;
	logic cmd_ok;
	logic start;
	logic [LAT_W-1:0] new_lat;
	logic [COL_W-1:0] beat_col;
	logic [DQ_W-1:0] rd_word;
	logic invert;

	function automatic logic [BEAT_W-1:0] zero_count(input logic [DQ_W-1:0] d);
		logic [BEAT_W-1:0] n;
		n = '0;
		for (int i = 0; i < DQ_W; i++)
		begin
			n = n + BEAT_W'(~d[i]);
		end
		zero_count = n;
	endfunction

	// Every link input is treated as asynchronous to ref_clk
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			syn1_q <= '0;
			syn2_q <= '0;
			ck_prev_q <= 1'b0;
		end
		else
		begin
			syn1_q <= {link.ck, link.cs_n, link.par, link.odt, link.cmd,
				link.addr, link.dq};
			syn2_q <= syn1_q;
			ck_prev_q <= ck_s;
		end
	end

	assign {ck_s, cs_n_s, par_s, odt_s, cmd_s, addr_s, dq_s} = syn2_q;
	assign rise = ck_s & ~ck_prev_q;

	// Command decode: with command latency the select edge only arms a count
	assign take = rise && ((state_q == D_IDLE && !cs_n_s
		&& cfg_q.cal == '0) || (state_q == D_CAL && cal_q == CAL_ONE)); // [R11]
	assign par_good = ((^{cmd_s, addr_s}) == par_s);
	assign cmd_ok = take && (!cfg_q.par || par_good);
	assign start = cmd_ok && (cmd_s == CMD_RD || cmd_s == CMD_WR);
	assign new_lat = (cmd_s == CMD_RD) ? read_lat(cfg_q) : write_lat(cfg_q); // [R4] [R5] [R9]

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cfg_q <= CFG_RST;
		else if (cmd_ok && cmd_s == CMD_MRS)
			cfg_q <= cfg_t'(addr_s);
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= D_IDLE;
			cal_q <= '0;
			lat_q <= '0;
			beat_q <= '0;
			len_q <= BEATS_BL8;
			col_q <= '0;
			is_wr_q <= 1'b0;
		end
		else if (start)
		begin
			lat_q <= new_lat - LAT_ONE;
			beat_q <= '0;
			len_q <= burst_beats(cfg_q.bf, addr_s[A12_BIT]); // [R1] [R2] [R3] [R10]
			col_q <= addr_s[COL_W-1:0];
			is_wr_q <= (cmd_s == CMD_WR);
			state_q <= (new_lat <= LAT_ONE) ? D_XFER : D_LAT;
		end
		else if (rise)
		begin
			case (state_q)
				D_IDLE:
				begin
					if (!cs_n_s && cfg_q.cal != '0)
					begin
						state_q <= D_CAL;
						cal_q <= cfg_q.cal; // [R11]
					end
				end
				D_CAL:
				begin
					cal_q <= cal_q - CAL_ONE;
					if (cal_q == CAL_ONE)
						state_q <= D_IDLE;
				end
				D_LAT:
				begin
					lat_q <= lat_q - LAT_ONE;
					if (lat_q == LAT_ONE)
						state_q <= D_XFER;
				end
				D_XFER:
				begin
					beat_q <= beat_q + 1'b1;
					if (beat_q == len_q - 1'b1)
						state_q <= D_IDLE;
				end
				default: state_q <= D_IDLE;
			endcase
		end
	end

	assign beat_col = col_q + beat_q[COL_W-1:0];
	assign rd_word = mem[beat_col];
	assign invert = cfg_q.rdbi && (zero_count(rd_word) > BEAT_W'(DBI_ZERO_LIMIT));

	// Writes land only while the DLL is locked; otherwise the beat is dropped
	always_ff @(posedge ref_clk)
	begin
		if (rise && state_q == D_XFER && is_wr_q && dll_q)
			mem[beat_col] <= dq_s; // [R7]
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dq_o_q <= '0;
			dq_oe_q <= 1'b0;
			dbi_n_q <= 1'b1;
		end
		else if (rise)
		begin
			if (state_q == D_XFER && !is_wr_q)
			begin
				dq_o_q <= invert ? ~rd_word : rd_word;
				dbi_n_q <= ~invert; // [R8]
				dq_oe_q <= 1'b1;
			end
			else
			begin
				dq_oe_q <= 1'b0;
				dbi_n_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dll_s1_q <= 1'b0;
			dll_q <= 1'b0;
			odt_q <= 1'b0;
			par_err_q <= 1'b0;
			wr_drop_q <= 1'b0;
		end
		else
		begin
			dll_s1_q <= dll_locked;
			dll_q <= dll_s1_q;
			// Termination follows the pin at every clock, never delayed by
			// the command latency count
			if (rise)
				odt_q <= odt_s; // [R6]
			par_err_q <= take && cfg_q.par && !par_good;
			wr_drop_q <= rise && state_q == D_XFER && is_wr_q && !dll_q; // [R7]
		end
	end

	assign link.dq_d_o = dq_o_q;
	assign link.dq_d_oe = dq_oe_q;
	assign link.dbi_n = dbi_n_q;
	assign link.dll_ok = dll_q;
	assign odt_active = odt_q;
	assign busy = (state_q != D_IDLE);
	assign par_err = par_err_q;
	assign wr_dropped = wr_drop_q;
endmodule
`default_nettype wire

// ---- bench/dram_link_chk.sv ----
// Checker for the link between the controller and the device end.
// Assumes every link signal is sampled on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module dram_link_chk
	import dram_lat_pkg::*;
#(
	parameter int CK_HALF = 4
)(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic ck,
	input wire logic cs_n,
	input wire logic [1:0] cmd,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic odt,
	input wire logic dq_c_oe,
	input wire logic dq_d_oe,
	input wire logic [DQ_W-1:0] dq,
	input wire logic dbi_n,
	input wire logic dll_ok
);
	logic ck_q;
	logic [2:0] wait_q;
	logic [7:0] lat_q;
	logic [7:0] crun_q;
	logic [7:0] drun_q;
	cfg_t cfg_q;
	logic rise;
	logic take;
	logic [7:0] rl;
	logic [7:0] wl;
	assign rise = ck && !ck_q;
	// A command lands cal edges after its select
	assign take = rise && (wait_q == 3'h1
		|| (wait_q == 3'h0 && !cs_n && cfg_q.cal == 3'h0));
	assign rl = 8'(cfg_q.cl) + 8'(cfg_q.al) + (cfg_q.par ? 8'h04 : 8'h00)
		+ (cfg_q.rdbi ? 8'h02 : 8'h00);
	assign wl = 8'(cfg_q.cwl) + 8'(cfg_q.al) + (cfg_q.par ? 8'h04 : 8'h00);
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			ck_q <= 1'b0;
		else
			ck_q <= ck;
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			wait_q <= 3'h0;
		else if (rise && wait_q != 3'h0)
			wait_q <= wait_q - 3'h1;
		else if (rise && !cs_n)
			wait_q <= cfg_q.cal;
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			cfg_q <= CFG_RST;
		else if (take && cmd == CMD_MRS)
			cfg_q <= cfg_t'(addr);
	// Link edges since the last command; saturates so it never wraps
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			lat_q <= 8'h00;
		else if (take)
			lat_q <= 8'h00;
		else if (rise && lat_q != 8'hff)
			lat_q <= lat_q + 8'h01;
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			crun_q <= 8'h00;
			drun_q <= 8'h00;
		end
		else
		begin
			crun_q <= dq_c_oe ? crun_q + 8'h01 : 8'h00;
			drun_q <= dq_d_oe ? drun_q + 8'h01 : 8'h00;
		end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	property p_wr_len;
		$fell(dq_c_oe) |-> crun_q == 8'(8 * CK_HALF)
			|| crun_q == 8'(16 * CK_HALF);
	endproperty
	a_wr_len: assert property (p_wr_len)
		else $error("write burst length wrong");
	property p_rd_len;
		$fell(dq_d_oe) |-> drun_q == 8'(8 * CK_HALF)
			|| drun_q == 8'(16 * CK_HALF);
	endproperty
	a_rd_len: assert property (p_rd_len)
		else $error("read burst length wrong");
	property p_rd_lat;
		$rose(dq_d_oe) |-> lat_q == rl;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read latency wrong");
	property p_wr_lat;
		$rose(dq_c_oe) |-> lat_q == wl - 8'h01;
	endproperty
	a_wr_lat: assert property (p_wr_lat)
		else $error("write latency wrong");
	property p_odt_cmd;
		$rose(odt) |-> cmd == CMD_WR;
	endproperty
	a_odt_cmd: assert property (p_odt_cmd)
		else $error("termination not raised with write command");
	property p_dll_wr;
		!dll_ok |-> !dq_c_oe;
	endproperty
	a_dll_wr: assert property (p_dll_wr)
		else $error("write data driven without lock");
	property p_dbi_idle;
		!dq_d_oe |-> dbi_n;
	endproperty
	a_dbi_idle: assert property (p_dbi_idle)
		else $error("inversion flag outside read beat");
	property p_dbi_inv;
		dq_d_oe && !dbi_n |-> $countones(dq) > DBI_ZERO_LIMIT;
	endproperty
	a_dbi_inv: assert property (p_dbi_inv)
		else $error("inverted beat has too many zeros");
	property p_cal_nop;
		rise && !cs_n && cfg_q.cal != 3'h0 |-> cmd == CMD_NOP;
	endproperty
	a_cal_nop: assert property (p_cal_nop)
		else $error("command driven with select under latency mode");
	property p_cs_len;
		$fell(cs_n) |-> !cs_n [*8] ##1 cs_n;
	endproperty
	a_cs_len: assert property (p_cs_len)
		else $error("select not one link clock long");
endmodule
`default_nettype wire

// ---- bench/dram_read_write_latency_modes_test.sv ----
// Bench joining controller and device ends over the link.
// Assumes a 125 MHz ref_clk and the controller register map.
`timescale 1ns/10ps
`default_nettype none
module dram_read_write_latency_modes_test
	import dram_lat_pkg::*;
	;
	logic ref_clk;
	logic sys_rst;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic wdata_ready;
	logic dll_locked;
	logic odt_active;
	logic dev_busy;
	logic par_err;
	logic wr_dropped;
	logic [31:0] s;
	int bad_count;
	int check_count;
	int c_cyc;
	int d_cyc;
	int inv_cyc;
	int fault_cnt;
	int odt_cyc;
	dram_link_if i_dram_link_if ();
	dram_ctl_end #(.CK_HALF(4), .FIFO_DEPTH(4)) i_dram_ctl_end (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .link(i_dram_link_if),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdata_ready(wdata_ready));
	dram_dev_end #(.MEM_WORDS(16)) i_dram_dev_end (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .link(i_dram_link_if),
		.dll_locked(dll_locked), .odt_active(odt_active), .busy(dev_busy),
		.par_err(par_err), .wr_dropped(wr_dropped));
	dram_link_chk #(.CK_HALF(4)) i_dram_link_chk (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .ck(i_dram_link_if.ck),
		.cs_n(i_dram_link_if.cs_n), .cmd(i_dram_link_if.cmd),
		.addr(i_dram_link_if.addr), .odt(i_dram_link_if.odt),
		.dq_c_oe(i_dram_link_if.dq_c_oe), .dq_d_oe(i_dram_link_if.dq_d_oe),
		.dq(i_dram_link_if.dq), .dbi_n(i_dram_link_if.dbi_n),
		.dll_ok(i_dram_link_if.dll_ok));
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		c_cyc += int'(i_dram_link_if.dq_c_oe);
		d_cyc += int'(i_dram_link_if.dq_d_oe);
		inv_cyc += int'(i_dram_link_if.dq_d_oe && !i_dram_link_if.dbi_n);
		fault_cnt += int'(par_err || wr_dropped);
		odt_cyc += int'(odt_active);
	end
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// Poll busy with a bound so a stuck burst cannot hang the run
	task automatic idle();
		int n;
		n = 0;
		do
		begin
			rd(REG_STATUS, s);
			n++;
		end
		while (s[ST_BUSY] !== 1'b0 && n < 500);
		chk("busy", 32'h0, {31'h0, s[ST_BUSY]});
		chk("device busy", 32'h0, {31'h0, dev_busy});
	endtask
	task automatic t_burst(input logic [1:0] bf, input logic a12,
		input logic par, input logic rdbi, input logic [2:0] cal,
		input logic [3:0] col);
		int n;
		int inv;
		logic [7:0] dat [8];
		n = (bf == BF_BC4 || (bf == BF_OTF && !a12)) ? 4 : 8;
		inv = 0;
		wr(REG_CFG, {10'h000, 15'h012b, cal, rdbi, par, bf});
		idle();
		for (int i = 0; i < 8; i++)
			dat[i] = i[0] ? 8'(8'he0 + i) : 8'(col + i);
		for (int i = 0; i < 4; i++)
			wr(REG_WDATA, {24'h0, dat[i]});
		chk("wdata_ready", 32'h0, {31'h0, wdata_ready});
		wr(REG_WDATA, 32'h0000_00aa);
		rd(REG_STATUS, s);
		chk("full refused", 32'h3, {30'h0, s[ST_REFUSED], s[ST_FULL]});
		wr(REG_STATUS, 32'h0000_0010);
		c_cyc = 0;
		d_cyc = 0;
		inv_cyc = 0;
		odt_cyc = 0;
		wr(REG_CMD, {26'h0, col, a12, 1'b1});
		for (int i = 4; i < n; i++)
		begin
			for (int k = 0; k < 200 && wdata_ready !== 1'b1; k++)
				@(posedge ref_clk);
			wr(REG_WDATA, {24'h0, dat[i]});
		end
		idle();
		chk("write cycles", 32'(n * 8), 32'(c_cyc));
		wr(REG_CMD, {26'h0, col, a12, 1'b0});
		idle();
		chk("read cycles", 32'(n * 8), 32'(d_cyc));
		chk("odt cycles", 32'((10 + n + (par ? 4 : 0)) * 8),
			32'(odt_cyc));
		for (int i = 0; i < n; i++)
			inv += (rdbi && $countones(dat[i]) < 4) ? 8 : 0;
		chk("inverted cycles", 32'(inv), 32'(inv_cyc));
		for (int i = 0; i < n; i++)
		begin
			rd(REG_RDATA + 8'(4 * i), s);
			chk("read data", {24'h0, dat[i]}, s);
		end
	endtask
	task automatic t_reset();
		rd(REG_STATUS, s);
		chk("status", 32'h0000_000a, s);
		rd(REG_CFG, s);
		chk("config", 32'h0000_9580, s);
		rd(8'h40, s);
		chk("unmapped", 32'h0, s);
	endtask
	// Writes must be refused while the device reports no lock
	task automatic t_dll();
		@(posedge ref_clk);
		dll_locked <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rd(REG_STATUS, s);
		chk("lock flag", 32'h0, {31'h0, s[ST_DLL]});
		for (int i = 0; i < 4; i++)
			wr(REG_WDATA, 32'h0000_0055);
		c_cyc = 0;
		wr(REG_CMD, 32'h0000_0001);
		repeat (400) @(posedge ref_clk);
		chk("unlocked write", 32'h0, 32'(c_cyc));
		rd(REG_STATUS, s);
		chk("refused", 32'h1, {31'h0, s[ST_REFUSED]});
		dll_locked <= 1'b1;
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		bad_count++;
		print_verdict();
	end
	initial
	begin
		sys_rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		dll_locked = 1'b1;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge ref_clk);
		t_reset();
		t_burst(BF_BL8, 1'b0, 1'b0, 1'b0, 3'h0, 4'h0);
		t_burst(BF_OTF, 1'b1, 1'b0, 1'b0, 3'h0, 4'h3);
		t_burst(BF_OTF, 1'b0, 1'b0, 1'b0, 3'h0, 4'h6);
		t_burst(BF_BC4, 1'b1, 1'b0, 1'b0, 3'h0, 4'hc);
		t_burst(BF_BL8, 1'b0, 1'b1, 1'b0, 3'h0, 4'hf);
		t_burst(BF_BL8, 1'b0, 1'b0, 1'b1, 3'h0, 4'h9);
		t_burst(BF_BL8, 1'b1, 1'b1, 1'b1, 3'h3, 4'h2);
		t_dll();
		chk("fault pulses", 32'h0, 32'(fault_cnt));
		print_verdict();
	end
endmodule
`default_nettype wire
